// file: include/hbw_pkg.sv
// package: shared constants for the hub bus write cycle
package hbw_pkg;
  localparam int          NIB_W          = 4;
  localparam int          ADDR_W         = 28;
  localparam int          ADDR_NIBS      = 7;
  localparam logic [3:0]  START_WRITE    = 4'he;
  localparam logic [3:0]  SIZE_ONE_BYTE  = 4'h0;
  localparam logic [3:0]  TURN_ONES      = 4'hf;
  localparam logic [3:0]  SYNC_READY     = 4'h0;
  localparam logic [2:0]  ADDR_LAST      = 3'h6;
endpackage

// file: include/hbw_if.sv
// interface: the four-line nibble bus and framing strobe between host and memory
`timescale 1ns/1ps
interface hbw_if;
  logic [3:0] host_nib_out;
  logic [3:0] host_nib_oe;
  logic [3:0] dev_nib_out;
  logic [3:0] dev_nib_oe;
  logic       frame_strobe_n;
  wire  [3:0] hub_nibble_io;

  // pulled-up bus: a line reads low only when some end drives it low
  genvar i;
  for (i = 0; i < 4; i++) begin : g_res
    assign hub_nibble_io[i] = (host_nib_oe[i] & ~host_nib_out[i]) | (dev_nib_oe[i] & ~dev_nib_out[i]) ? 1'b0 : 1'b1;
  end

  modport device (
    input  frame_strobe_n,
    input  hub_nibble_io,
    output dev_nib_out,
    output dev_nib_oe
  );
  modport host (
    output frame_strobe_n,
    input  hub_nibble_io,
    output host_nib_out,
    output host_nib_oe
  );
endinterface

// file: hw/hbw_device.sv
// module: memory-side receiver of a hub bus single-byte write
`timescale 1ns/1ps
module hbw_device
  import hbw_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        interface_reset_n,
  input  wire logic        cpu_reset_n,
  input  wire logic [3:0]  id_strap_inputs,
  hbw_if.device            bus,
  output logic [27:0]      cmd_addr,
  output logic [7:0]       cmd_data,
  output logic             cmd_valid,
  output logic             size_error,
  output logic             read_mode
);

  // ==========
  // state encoding
  // ==========
  // state held during each bus cycle, cycle 1 being the one with frame low:
  //   idle  cycle 1, start code sampled at its end
  //   id    cycle 2, id nibble sampled
  //   addr  cycles 3-9, seven address nibbles
  //   size  cycle 10
  //   dlo   cycle 11, dhi cycle 12
  //   tar1  cycle 13, host still drives ones
  //   tar2  cycle 14, nobody drives; the enable is registered for 15
  //   sync  cycle 15, zero code out
  //   tar3  cycle 16, ones out; the lines are released for 17
  //   idle again in cycle 17, so a new frame may begin in cycle 18
  typedef enum logic [9:0] {
    S_IDLE = 10'h001,
    S_ID   = 10'h002,
    S_ADDR = 10'h004,
    S_SIZE = 10'h008,
    S_DLO  = 10'h010,
    S_DHI  = 10'h020,
    S_TAR1 = 10'h040,
    S_TAR2 = 10'h080,
    S_SYNC = 10'h100,
    S_TAR3 = 10'h200
  } hbw_state_e;

  // ==========
  // state record
  // ==========
  // one record, so reset and next-state logic cannot drift apart
  typedef struct packed {
    hbw_state_e  st;
    logic        hit;
    logic        size_ok;
    logic [2:0]  cnt;
    logic [27:0] addr;
    logic [7:0]  data;
    logic [27:0] cmd_addr;
    logic [7:0]  cmd_data;
    logic        cmd_valid;
    logic        size_error;
    logic        read_mode;
    logic [3:0]  nib_out;
    logic [3:0]  nib_oe;
  } hbw_dev_s;

  hbw_dev_s s_r;
  hbw_dev_s s_nxt;
  logic     any_reset;

  // ==========
  // helpers
  // ==========
  // one nibble compare for start, id and size decode
  function automatic logic nib_is(input logic [3:0] nib, input logic [3:0] code);
    return nib == code;
  endfunction

  // most significant nibble arrives first, so each new one enters at the bottom
  function automatic logic [27:0] addr_shift(input logic [27:0] acc, input logic [3:0] nib);
    return {acc[23:0], nib};
  endfunction

  // ==========
  // reset merge
  // ==========
  // either reset pin alone deselects the memory; the bus reset joins them
  // all resets are sampled on the clock, so a pulse between two edges is missed
  assign any_reset = rst | ~interface_reset_n | ~cpu_reset_n;

  // ==========
  // next state
  // ==========
  always_comb begin
    s_nxt           = s_r;
    s_nxt.cmd_valid = 1'b0;
    s_nxt.nib_oe    = 4'h0;
    s_nxt.nib_out   = TURN_ONES;
    unique case (s_r.st)
      S_IDLE: begin
        if (!bus.frame_strobe_n && nib_is(bus.hub_nibble_io, START_WRITE)) begin
          s_nxt.st = S_ID;
        end
      end
      S_ID: begin
        s_nxt.hit = nib_is(bus.hub_nibble_io, id_strap_inputs);
        s_nxt.cnt = 3'h0;
        s_nxt.st  = S_ADDR;
      end
      S_ADDR: begin
        // an unaddressed memory still walks the frame to stay in step, but keeps nothing
        if (s_r.hit) begin
          s_nxt.addr = addr_shift(s_r.addr, bus.hub_nibble_io);
        end
        s_nxt.cnt  = s_r.cnt + 3'h1;
        if (s_r.cnt == ADDR_LAST) begin
          s_nxt.st = S_SIZE;
        end
      end
      S_SIZE: begin
        s_nxt.size_ok = nib_is(bus.hub_nibble_io, SIZE_ONE_BYTE);
        s_nxt.st      = S_DLO;
      end
      S_DLO: begin
        if (s_r.hit) begin
          s_nxt.data[3:0] = bus.hub_nibble_io;
        end
        s_nxt.st = S_DHI;
      end
      S_DHI: begin
        if (s_r.hit) begin
          s_nxt.data[7:4] = bus.hub_nibble_io;
        end
        s_nxt.st = S_TAR1;
      end
      S_TAR1: begin
        // host drives ones here; we still only listen
        s_nxt.st = S_TAR2;
      end
      S_TAR2: begin
        // take ownership: enable lands on the sync cycle
        if (s_r.hit) begin
          s_nxt.nib_oe  = 4'hf;
          s_nxt.nib_out = SYNC_READY;
        end
        s_nxt.st = S_SYNC;
      end
      S_SYNC: begin
        // a wrong size is still acknowledged, but nothing reaches the command side
        if (s_r.hit) begin
          s_nxt.nib_oe  = 4'hf;
          s_nxt.nib_out = TURN_ONES;
          if (s_r.size_ok) begin
            s_nxt.cmd_addr  = s_r.addr;
            s_nxt.cmd_data  = s_r.data;
            s_nxt.cmd_valid = 1'b1;
            s_nxt.read_mode = 1'b0;
          end else begin
            s_nxt.size_error = 1'b1;
          end
        end
        s_nxt.st = S_TAR3;
      end
      S_TAR3: begin
        s_nxt.st = S_IDLE; // ones still driven this cycle; outputs float from the next
      end
      default: s_nxt.st = S_IDLE;
    endcase
  end

  // ==========
  // state register
  // ==========
  // reset loads constants only: lines float and read mode returns
  always_ff @(posedge core_clk) begin
    if (any_reset) begin
      s_r           <= '0;
      s_r.st        <= S_IDLE;
      s_r.nib_out   <= TURN_ONES;
      s_r.read_mode <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========
  // outputs
  // ==========
  assign bus.dev_nib_out = s_r.nib_out;
  assign bus.dev_nib_oe  = s_r.nib_oe;
  assign cmd_addr        = s_r.cmd_addr;
  assign cmd_data        = s_r.cmd_data;
  assign cmd_valid       = s_r.cmd_valid;
  assign size_error      = s_r.size_error;
  assign read_mode       = s_r.read_mode;
endmodule

// file: hw/hbw_host.sv
// module: host-side driver of a hub bus single-byte write
`timescale 1ns/1ps
module hbw_host
  import hbw_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        req_valid,
  input  wire logic [3:0]  req_id,
  input  wire logic [27:0] req_addr,
  input  wire logic [7:0]  req_data,
  hbw_if.host              bus,
  output logic             req_ready,
  output logic             done,
  output logic             sync_ok
);
  typedef enum logic [10:0] {
    H_IDLE  = 11'h001,
    H_START = 11'h002,
    H_ID    = 11'h004,
    H_ADDR  = 11'h008,
    H_SIZE  = 11'h010,
    H_DLO   = 11'h020,
    H_DHI   = 11'h040,
    H_TAR1  = 11'h080,
    H_TAR2  = 11'h100,
    H_SYNC  = 11'h200,
    H_TAR3  = 11'h400
  } hbw_hstate_e;

  typedef struct packed {
    hbw_hstate_e st;
    logic [2:0]  cnt;
    logic [3:0]  id;
    logic [27:0] addr;
    logic [7:0]  data;
    logic [3:0]  nib_out;
    logic [3:0]  nib_oe;
    logic        frame_n;
    logic        ready;
    logic        done;
    logic        sync_ok;
  } hbw_host_s;

  hbw_host_s s_r;
  hbw_host_s s_nxt;

  // registers hold the value driven during the next cycle
  always_comb begin
    s_nxt         = s_r;
    s_nxt.done    = 1'b0;
    s_nxt.frame_n = 1'b1;
    s_nxt.nib_oe  = 4'hf;
    s_nxt.nib_out = TURN_ONES;
    unique case (s_r.st)
      H_IDLE: begin
        if (req_valid) begin
          s_nxt.id      = req_id;
          s_nxt.addr    = req_addr;
          s_nxt.data    = req_data;
          s_nxt.ready   = 1'b0;
          s_nxt.frame_n = 1'b0;
          s_nxt.nib_out = START_WRITE;
          s_nxt.st      = H_START;
        end
      end
      H_START: begin
        s_nxt.nib_out = s_r.id;
        s_nxt.st      = H_ID;
      end
      H_ID: begin
        s_nxt.nib_out = s_r.addr[27:24];
        s_nxt.addr    = {s_r.addr[23:0], 4'h0};
        s_nxt.cnt     = 3'h0;
        s_nxt.st      = H_ADDR;
      end
      H_ADDR: begin
        if (s_r.cnt == ADDR_LAST) begin
          s_nxt.nib_out = SIZE_ONE_BYTE;
          s_nxt.st      = H_SIZE;
        end else begin
          s_nxt.nib_out = s_r.addr[27:24];
          s_nxt.addr    = {s_r.addr[23:0], 4'h0};
          s_nxt.cnt     = s_r.cnt + 3'h1;
        end
      end
      H_SIZE: begin
        s_nxt.nib_out = s_r.data[3:0];
        s_nxt.st      = H_DLO;
      end
      H_DLO: begin
        s_nxt.nib_out = s_r.data[7:4];
        s_nxt.st      = H_DHI;
      end
      H_DHI: begin
        s_nxt.nib_out = TURN_ONES;
        s_nxt.st      = H_TAR1;
      end
      H_TAR1: begin
        s_nxt.nib_oe = 4'h0; // release before the memory drives
        s_nxt.st     = H_TAR2;
      end
      H_TAR2: begin
        s_nxt.nib_oe = 4'h0;
        s_nxt.st     = H_SYNC;
      end
      H_SYNC: begin
        s_nxt.nib_oe  = 4'h0;
        s_nxt.sync_ok = (bus.hub_nibble_io == SYNC_READY);
        s_nxt.st      = H_TAR3;
      end
      H_TAR3: begin
        // memory drives ones this cycle and floats from the next, when we drive again
        s_nxt.done  = 1'b1;
        s_nxt.ready = 1'b1;
        s_nxt.st    = H_IDLE;
      end
      default: s_nxt.st = H_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_r         <= '0;
      s_r.st      <= H_IDLE;
      s_r.nib_out <= TURN_ONES;
      s_r.nib_oe  <= 4'hf;
      s_r.frame_n <= 1'b1;
      s_r.ready   <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bus.host_nib_out   = s_r.nib_out;
  assign bus.host_nib_oe    = s_r.nib_oe;
  assign bus.frame_strobe_n = s_r.frame_n;
  assign req_ready          = s_r.ready;
  assign done               = s_r.done;
  assign sync_ok            = s_r.sync_ok;
endmodule

// file: tb/hbw_chk.sv
// checker: wire timing of the hub bus write cycle
`timescale 1ns/1ps
module hbw_chk
  import hbw_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       frame_strobe_n,
  input wire logic [3:0] hub_nibble_io,
  input wire logic [3:0] host_nib_oe,
  input wire logic [3:0] dev_nib_oe
);
  // ==========
  // cycle count
  // ==========
  logic [4:0] cyc_r;
  // bus cycle on the wire, 0 idle and in cycle 1; a frame mid-transfer does not restart it
  always_ff @(posedge core_clk) begin
    cyc_r <= (rst || cyc_r == 5'h11) ? 5'h0 : (cyc_r != 5'h0) ? cyc_r + 5'h1 : {3'h0, !frame_strobe_n, 1'b0};
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // ==========
  // properties
  // ==========
  start_code_a: assert property (!frame_strobe_n |-> cyc_r == 5'h0 && hub_nibble_io == START_WRITE)
    else $error("bad start");
  host_turn_a: assert property (cyc_r == 5'hd |-> &host_nib_oe && hub_nibble_io == TURN_ONES)
    else $error("bad host turn");
  bus_float_a: assert property (cyc_r == 5'he |-> (host_nib_oe | dev_nib_oe) == 4'h0)
    else $error("bus driven in handover");
  sync_code_a: assert property (cyc_r == 5'hf && |dev_nib_oe |-> &dev_nib_oe && hub_nibble_io == SYNC_READY)
    else $error("bad sync");
  turn_back_a: assert property (cyc_r == 5'hf && |dev_nib_oe |-> ##1 &dev_nib_oe && hub_nibble_io == TURN_ONES)
    else $error("bad turn back");
  dev_release_a: assert property (cyc_r == 5'h11 |-> dev_nib_oe == 4'h0 && &host_nib_oe)
    else $error("bus not handed back");
  dev_window_a: assert property (|dev_nib_oe |-> cyc_r == 5'hf || cyc_r == 5'h10)
    else $error("device drives out of turn");
  host_quiet_a: assert property (cyc_r inside {5'hf, 5'h10} |-> host_nib_oe == 4'h0)
    else $error("host drives in device turn");
  sync_c: cover property (cyc_r == 5'hf && &dev_nib_oe);
  quiet_c: cover property (cyc_r == 5'hf && dev_nib_oe == 4'h0);
  b2b_c: cover property (cyc_r == 5'h11 ##1 !frame_strobe_n);
endmodule

// file: tb/test_hub_bus_write_cycle_target.sv
// testbench: host and memory ends of the hub bus write cycle
`timescale 1ns/1ps
module test_hub_bus_write_cycle_target
  import hbw_pkg::*;
;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        irst_n = 1'b1;
  logic        crst_n = 1'b1;
  logic        req_valid = 1'b0;
  logic [3:0]  req_id = 4'h0;
  logic [3:0]  strap = 4'h0;
  logic [27:0] req_addr = 28'h0;
  logic [7:0]  req_data = 8'h0;
  logic [51:0] n2;
  logic [31:0] lf = 32'h4a1a;
  logic [35:0] exp_q[$];
  logic        req_ready, done, sync_ok, cmd_valid, size_error, read_mode, cv2, se2;
  logic [27:0] cmd_addr;
  logic [7:0]  cmd_data;
  int          error_cnt = 0, total_checks = 0, cycles = 0, bad2 = 0;
  hbw_if hb();
  hbw_if hb2();
  hbw_host u_hbw_host(.core_clk, .rst, .req_valid, .req_id, .req_addr, .req_data, .bus(hb), .req_ready, .done,
    .sync_ok);
  hbw_device u_hbw_device(.core_clk, .rst, .interface_reset_n(irst_n), .cpu_reset_n(crst_n), .id_strap_inputs(strap),
    .bus(hb), .cmd_addr, .cmd_data, .cmd_valid, .size_error, .read_mode);
  // second memory faces a bench driver that sends a bad size nibble
  hbw_device u_hbw_device_2(.core_clk, .rst, .interface_reset_n(1'b1), .cpu_reset_n(1'b1), .id_strap_inputs(strap),
    .bus(hb2), .cmd_addr(), .cmd_data(), .cmd_valid(cv2), .size_error(se2), .read_mode());
  hbw_chk u_hbw_chk(.core_clk, .rst, .frame_strobe_n(hb.frame_strobe_n), .hub_nibble_io(hb.hub_nibble_io),
    .host_nib_oe(hb.host_nib_oe), .dev_nib_oe(hb.dev_nib_oe));
  // ==========
  // helpers
  // ==========
  initial forever #5 core_clk = ~core_clk;
  function automatic logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input logic [35:0] s, input logic [35:0] e);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // one write through the host, bus watched cycle by cycle
  task automatic wr(input logic [3:0] id, input logic [35:0] ad);
    logic [47:0] n;
    logic        hit;
    n = {id, ad[35:8], SIZE_ONE_BYTE, ad[3:0], ad[7:4], TURN_ONES};
    hit = (id == strap);
    if (hit) exp_q.push_back(ad);
    {req_valid, req_id, req_addr, req_data} = {1'b1, id, ad};
    while (req_ready !== 1'b1) @(negedge core_clk);
    for (int k = 1; k < 18; k++) begin
      @(negedge core_clk);
      req_valid = 1'b0;
      if (k == 1) chk({hb.frame_strobe_n, hb.hub_nibble_io, req_ready}, {1'b0, START_WRITE, 1'b0});
      else if (k < 14) chk(hb.hub_nibble_io, n[55 - 4 * k -: 4]);
      else if (k == 15) chk(hb.hub_nibble_io, hit ? SYNC_READY : 4'hf);
      else if (k == 17) chk({done, sync_ok, req_ready}, {1'b1, hit, 1'b1});
      else chk({done, hb.hub_nibble_io}, {1'b0, TURN_ONES});
    end
  endtask
  always @(negedge core_clk) begin
    if (cv2 === 1'b1) bad2++;
    if (cmd_valid === 1'b1) begin
      if (exp_q.size() == 0) chk(36'h0, 36'h1);
      else chk({cmd_addr, cmd_data}, exp_q.pop_front());
    end
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 1000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  // ==========
  // scenarios
  // ==========
  initial begin
    hb2.frame_strobe_n = 1'b1;
    hb2.host_nib_oe = 4'h0;
    hb2.host_nib_out = 4'hf;
    repeat (3) @(negedge core_clk);
    rst = 1'b0;
    chk({read_mode, size_error}, 2'b10);
    strap = lf[3:0];
    for (int j = 0; j < 6; j++) begin
      lf = nx(lf);
      wr(strap, {lf[27:0], lf[31:24]});
    end
    chk(read_mode, 1'b0);
    $display("test matched writes finished");
    for (int j = 1; j < 4; j++) wr(strap ^ 4'(j), {lf[27:0], 8'ha5});
    $display("test foreign id finished");
    for (int j = 0; j < 2; j++) begin
      wr(strap, {lf[31:4], 8'h3c});
      @(negedge core_clk);
      {irst_n, crst_n} = j ? 2'b10 : 2'b01;
      @(negedge core_clk);
      {irst_n, crst_n} = 2'b11;
      chk({read_mode, hb.dev_nib_oe}, 5'h10);
    end
    n2 = {START_WRITE, strap, lf[27:0], 4'h1, 4'hc, 4'h3, TURN_ONES};
    hb2.host_nib_oe = 4'hf;
    for (int k = 0; k < 13; k++) begin
      hb2.frame_strobe_n = (k != 0);
      hb2.host_nib_out = n2[51 - 4 * k -: 4];
      @(negedge core_clk);
    end
    hb2.host_nib_oe = 4'h0;
    @(negedge core_clk);
    chk(hb2.hub_nibble_io, SYNC_READY);
    repeat (5) @(negedge core_clk);
    chk({se2, 31'(bad2)}, {1'b1, 31'h0});
    chk(36'(exp_q.size()), 36'h0);
    $display("test reset and size finished");
    report_and_stop();
  end
endmodule
